// [inc/port_cfg.svh]
`ifndef PORT_CFG_SVH
`define PORT_CFG_SVH

// DSP output word bit positions
`define WB_REARM     13
`define WB_IRQ       11
`define WB_RDC       9
`define WB_CDC       8
`define WB_GUARD_HI  7
`define WB_GUARD_LO  6
`define WB_OUT_F     5
`define WB_OUT_E     4
`define WB_IO_D      3
`define WB_IO_C      2
`define WB_IO_B      1
`define WB_IO_A      0
`define WR_WIDTH     16
`define LVL_WIDTH    8
`define LVL_RESET    8'h00

// Pin indices
`define NUM_IO       4
`define NUM_PINS     6
`define PIN_A        0
`define PIN_B        1
`define PIN_C        2
`define PIN_D        3
`define PIN_E        4
`define PIN_F        5
`define PINS_RESET   6'h00
`define OE_N_RESET   6'h3f

// Condition inputs 48 to 55
`define COND_WIDTH   8

// ALU
`define DATA_W       32
`define SHAMT_W      5
`define DATA_ZERO    32'h0000_0000
`define DATA_MIN     32'h8000_0000
`define DATA_ONES    32'hffff_ffff

`endif

// [inc/port_pkg.sv]
`include "port_cfg.svh"

package port_pkg;

    typedef enum logic [2:0] {
        op_add,
        op_sub,
        op_mult,
        op_div,
        op_move,
        op_shl,
        op_shr
    } alu_op_t;

    typedef struct packed {
        logic overflow;
        logic carry;
        logic zero;
        logic positive;
    } alu_flags_t;

    typedef struct packed {
        logic [`NUM_PINS-1:0] value;
        logic [`NUM_PINS-1:0] oe_n;
    } pin_drive_t;

    typedef struct packed {
        logic cap_meas_kick;
        logic resist_meas_kick;
        logic cap_meas_rearm;
        logic watchdog_restart;
        logic init_reset;
    } meas_pulse_t;

    typedef enum logic {
        guard_idle,
        guard_high
    } guard_state_t;

endpackage : port_pkg

// [verilog/dsp_port_flags.sv]
`timescale 1ns/1ps
`include "port_cfg.svh"

module dsp_port_flags
    import port_pkg::*;
(
    input  wire logic                   clock,
    input  wire logic                   resetn,
    input  wire logic                   wr_en,
    input  wire logic [`WR_WIDTH-1:0]   wr_data,
    output logic      [`NUM_IO-1:0]     io_rd_bits,
    output meas_pulse_t                 meas_pulse,
    input  wire logic                   alu_valid,
    input  alu_op_t                     alu_op,
    input  wire logic [`DATA_W-1:0]     alu_a,
    input  wire logic [`DATA_W-1:0]     alu_b,
    output logic      [`DATA_W-1:0]     alu_result,
    output alu_flags_t                  alu_flags,
    input  wire logic                   spi_mode,
    input  wire logic                   spi_miso,
    input  wire logic                   pulse_code_a,
    input  wire logic                   pulse_code_b,
    input  wire logic                   pulse_a_en,
    input  wire logic                   pulse_b_en,
    input  wire logic                   pulse_a_to_c,
    input  wire logic                   pulse_b_to_d,
    input  wire logic [`NUM_IO-1:0]     pin_dir_in,
    input  wire logic [`NUM_IO-1:0]     latch_mask,
    input  wire logic [1:0]             start_pin_sel,
    input  wire logic                   dsp_stop,
    input  wire logic                   guard_mux_select,
    input  wire logic                   pin_e_guard_sel,
    input  wire logic                   irq_on_pin_e_en,
    input  wire logic                   irq_on_pin_f_en,
    input  wire logic                   irq_release,
    input  wire logic [`NUM_PINS-1:0]   pin_in,
    output pin_drive_t                  pin_drive,
    output logic                        spi_ssn,
    output logic                        irq_line_n,
    output logic                        dsp_start,
    output logic      [`COND_WIDTH-1:0] cond_inputs
);

    logic [`LVL_WIDTH-1:0] level_reg;
    logic [`LVL_WIDTH-1:0] level_next;
    meas_pulse_t           pulse_reg;
    meas_pulse_t           pulse_next;
    logic                  irq_reg;
    logic                  irq_next;
    logic [`NUM_PINS-1:0]  pin_meta_reg;
    logic [`NUM_PINS-1:0]  pin_sync_reg;
    logic [`NUM_IO-1:0]    pin_prev_reg;
    logic [`NUM_IO-1:0]    latch_reg;
    logic [`NUM_IO-1:0]    latch_next;
    logic [`NUM_IO-1:0]    fall;
    logic [`NUM_IO-1:0]    rd_next;
    logic                  start_reg;
    logic                  start_next;
    guard_state_t          guard_reg;
    guard_state_t          guard_next;
    logic                  guard_hi_seen_reg;
    logic                  guard_hi_seen_next;
    pin_drive_t            drive_reg;
    pin_drive_t            drive_next;
    logic                  ssn_reg;
    logic [`DATA_W-1:0]    result_reg;
    logic [`DATA_W-1:0]    result_next;
    alu_flags_t            flags_reg;
    alu_flags_t            flags_next;

    // Write decode
    wire logic wr_cdc   = wr_en & wr_data[`WB_CDC];
    wire logic wr_rdc   = wr_en & wr_data[`WB_RDC];
    wire logic wr_rearm = wr_en & wr_data[`WB_REARM];
    wire logic wr_irq   = wr_en & wr_data[`WB_IRQ];
    wire logic guard_hi = level_reg[`WB_GUARD_HI];
    wire logic guard_lo = level_reg[`WB_GUARD_LO];

    assign level_next = wr_en ? wr_data[`LVL_WIDTH-1:0] : level_reg;

    // guard pattern sequence
    // Bit 6 must go low, high, low again; bit 7 picks the action and must hold.
    wire logic guard_rise = (guard_reg == guard_idle) & guard_lo;
    wire logic guard_fall = (guard_reg == guard_high) & ~guard_lo;
    wire logic guard_ok   = guard_fall & (guard_hi == guard_hi_seen_reg);
    assign guard_next         = guard_rise ? guard_high
                              : guard_fall ? guard_idle : guard_reg;
    assign guard_hi_seen_next = guard_rise ? guard_hi : guard_hi_seen_reg;

    assign pulse_next.resist_meas_kick = wr_rdc;
    assign pulse_next.cap_meas_kick    = wr_cdc;
    assign pulse_next.cap_meas_rearm   = wr_rearm;
    assign pulse_next.watchdog_restart = guard_ok & ~guard_hi_seen_reg;
    assign pulse_next.init_reset       = guard_ok & guard_hi_seen_reg;

    // release, set wins
    // Write wins over release so no request is lost
    assign irq_next = wr_irq ? 1'b0 : (irq_release ? 1'b1 : irq_reg);

    genvar gi;
    generate
        for (gi = 0; gi < `NUM_IO; gi = gi + 1) begin : g_latch
            assign fall[gi] = latch_mask[gi] & pin_dir_in[gi]
                            & pin_prev_reg[gi] & ~pin_sync_reg[gi];
            // Fresh fall wins over stop
            assign latch_next[gi] = fall[gi] | (latch_reg[gi] & ~dsp_stop);
            assign rd_next[gi] = pin_dir_in[gi] ? pin_sync_reg[gi] : level_reg[gi];
        end
    endgenerate

    // Start pulse only from the selected pin
    assign start_next = fall[start_pin_sel];

    wire logic pa_on_a = pulse_a_en & ~pulse_a_to_c;
    wire logic pa_on_c = pulse_a_en & pulse_a_to_c;
    wire logic pb_on_b = pulse_b_en & ~pulse_b_to_d;
    wire logic pb_on_d = pulse_b_en & pulse_b_to_d;

    // SPI takes pins a and b
    assign drive_next.value[`PIN_A] = level_reg[`WB_IO_A] | (pa_on_a & pulse_code_a);
    assign drive_next.oe_n[`PIN_A]  = spi_mode | (pin_dir_in[`PIN_A] & ~pa_on_a);
    assign drive_next.value[`PIN_B] = spi_mode ? spi_miso
                                    : level_reg[`WB_IO_B] | (pb_on_b & pulse_code_b);
    assign drive_next.oe_n[`PIN_B]  = ~spi_mode & pin_dir_in[`PIN_B] & ~pb_on_b;
    // pin c io bit or pulse a
    assign drive_next.value[`PIN_C] = level_reg[`WB_IO_C] | (pa_on_c & pulse_code_a);
    assign drive_next.oe_n[`PIN_C]  = pin_dir_in[`PIN_C] & ~pa_on_c;
    // pin d io bit or pulse b
    assign drive_next.value[`PIN_D] = level_reg[`WB_IO_D] | (pb_on_d & pulse_code_b);
    assign drive_next.oe_n[`PIN_D]  = pin_dir_in[`PIN_D] & ~pb_on_d;

    // irq on pin e or f
    // pins e and f output only
    // output bits on e and f
    assign drive_next.value[`PIN_E] = irq_on_pin_e_en ? irq_reg
                                    : pin_e_guard_sel ? guard_mux_select
                                    : level_reg[`WB_OUT_E];
    assign drive_next.value[`PIN_F] = irq_on_pin_f_en ? irq_reg : level_reg[`WB_OUT_F];
    assign drive_next.oe_n[`PIN_E]  = 1'b0;
    assign drive_next.oe_n[`PIN_F]  = 1'b0;

    // ALU arithmetic
    wire logic [`DATA_W:0]       add_sum  = {1'b0, alu_a} + {1'b0, alu_b};
    // Carry of a plus inverted b plus one
    wire logic [`DATA_W:0]       sub_sum  = {1'b0, alu_a} + {1'b0, ~alu_b} + 33'h1_0000_0001
                                          - 33'h1_0000_0000;
    wire logic signed [2*`DATA_W-1:0] sprod = $signed(alu_a) * $signed(alu_b);
    wire logic [2*`DATA_W-1:0]   uprod    = alu_a * alu_b;
    wire logic                   div_zero = (alu_b == `DATA_ZERO);
    wire logic                   div_wrap = (alu_a == `DATA_MIN) & (alu_b == `DATA_ONES);
    // Divide by zero or min by minus one gives zero
    wire logic [`DATA_W-1:0]     quot     = (div_zero | div_wrap) ? `DATA_ZERO
                                          : $unsigned($signed(alu_a) / $signed(alu_b));
    // Shift amount is the low five bits of b
    wire logic [`DATA_W-1:0]     shl_res  = alu_a << alu_b[`SHAMT_W-1:0];
    wire logic [`DATA_W-1:0]     shr_res  = alu_a >> alu_b[`SHAMT_W-1:0];
    wire logic sa = alu_a[`DATA_W-1];
    wire logic sb = alu_b[`DATA_W-1];
    wire logic add_ovf  = (sa == sb) & (add_sum[`DATA_W-1] != sa);
    wire logic sub_ovf  = (sa != sb) & (sub_sum[`DATA_W-1] != sa);
    wire logic mult_ovf = (sprod[2*`DATA_W-1:`DATA_W-1] != {(`DATA_W+1){1'b0}})
                        & (sprod[2*`DATA_W-1:`DATA_W-1] != {(`DATA_W+1){1'b1}});
    wire logic mult_cy  = (uprod[2*`DATA_W-1:`DATA_W] != `DATA_ZERO);

    always_comb begin
        result_next = result_reg;
        flags_next  = flags_reg;
        if (alu_valid) begin
            flags_next.overflow = 1'b0;
            flags_next.carry    = 1'b0;
            unique case (alu_op)
                op_add: begin
                    result_next         = add_sum[`DATA_W-1:0];
                    flags_next.overflow = add_ovf;
                    flags_next.carry    = add_sum[`DATA_W];
                end
                op_sub: begin
                    result_next         = sub_sum[`DATA_W-1:0];
                    flags_next.overflow = sub_ovf;
                    flags_next.carry    = sub_sum[`DATA_W];
                end
                op_mult: begin
                    result_next         = sprod[`DATA_W-1:0];
                    flags_next.overflow = mult_ovf;
                    flags_next.carry    = mult_cy;
                end
                op_div: begin
                    result_next         = quot;
                    flags_next.overflow = div_zero | div_wrap;
                end
                // Move and shifts leave overflow and carry clear
                op_move: result_next = alu_a;
                op_shl:  result_next = shl_res;
                op_shr:  result_next = shr_res;
                default: result_next = result_reg;
            endcase
            flags_next.zero     = (result_next == `DATA_ZERO);
            flags_next.positive = ~result_next[`DATA_W-1];
        end
    end

    // Pin synchroniser, first stage read only by second
    // Prev resets low, so pins idling high give no false fall
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pin_meta_reg <= `PINS_RESET;
            pin_sync_reg <= `PINS_RESET;
            pin_prev_reg <= {`NUM_IO{1'b0}};
        end else begin
            pin_meta_reg <= pin_in;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg[`NUM_IO-1:0];
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            level_reg         <= `LVL_RESET;
            pulse_reg         <= '0;
            irq_reg           <= 1'b1;
            guard_reg         <= guard_idle;
            guard_hi_seen_reg <= 1'b0;
        end else begin
            level_reg         <= level_next;
            pulse_reg         <= pulse_next;
            irq_reg           <= irq_next;
            guard_reg         <= guard_next;
            guard_hi_seen_reg <= guard_hi_seen_next;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            latch_reg <= {`NUM_IO{1'b0}};
            start_reg <= 1'b0;
            ssn_reg   <= 1'b1;
            io_rd_bits <= {`NUM_IO{1'b0}};
            drive_reg.value <= `PINS_RESET;
            drive_reg.oe_n  <= `OE_N_RESET;
        end else begin
            latch_reg <= latch_next;
            start_reg <= start_next;
            ssn_reg   <= ~spi_mode | pin_sync_reg[`PIN_A];
            io_rd_bits <= rd_next;
            drive_reg <= drive_next;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            result_reg <= `DATA_ZERO;
            flags_reg  <= '0;
        end else begin
            result_reg <= result_next;
            flags_reg  <= flags_next;
        end
    end

    assign meas_pulse = pulse_reg;
    assign irq_line_n = irq_reg;
    assign dsp_start  = start_reg;
    assign pin_drive  = drive_reg;
    assign spi_ssn    = ssn_reg;
    assign alu_result = result_reg;
    assign alu_flags  = flags_reg;
    assign cond_inputs = {{(`COND_WIDTH-`NUM_IO){1'b0}}, latch_reg};

endmodule : dsp_port_flags

// [dv/dsp_port_flags_monitor.sv]
`timescale 1ns/1ps
`include "port_cfg.svh"
module dsp_port_flags_monitor
    import port_pkg::*;
(
    input wire logic                 clock,
    input wire logic                 resetn,
    input wire logic                 wr_en,
    input wire logic [`WR_WIDTH-1:0] wr_data,
    input meas_pulse_t               meas_pulse,
    input wire logic                 alu_valid,
    input alu_op_t                   alu_op,
    input wire logic [`DATA_W-1:0]   alu_a,
    input wire logic [`DATA_W-1:0]   alu_b,
    input wire logic [`DATA_W-1:0]   alu_result,
    input alu_flags_t                alu_flags,
    input wire logic                 irq_release,
    input wire logic                 irq_line_n
);
    logic [`DATA_W:0] sum_w;
    logic             irq_w;
    logic             add_w;
    assign sum_w = {1'b0, alu_a} + {1'b0, alu_b};
    assign irq_w = wr_en && wr_data[`WB_IRQ];
    assign add_w = alu_valid && alu_op == op_add;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    kick_cap_a: assert property (
        meas_pulse.cap_meas_kick == $past(wr_en && wr_data[`WB_CDC])) else $error("cap kick");
    kick_res_a: assert property (
        meas_pulse.resist_meas_kick == $past(wr_en && wr_data[`WB_RDC])) else $error("res kick");
    rearm_pulse_a: assert property (
        meas_pulse.cap_meas_rearm == $past(wr_en && wr_data[`WB_REARM])) else $error("rearm");
    irq_set_a: assert property (irq_w |=> !irq_line_n) else $error("irq not set");
    irq_free_a: assert property (
        irq_release && !irq_w |=> irq_line_n) else $error("irq not released");
    guard_wd_a: assert property (meas_pulse.watchdog_restart |->
        $past(wr_en, 2) && !$past(wr_data[6], 2) && !$past(wr_data[7], 2)) else $error("wd");
    guard_init_a: assert property (meas_pulse.init_reset |->
        $past(wr_en, 2) && !$past(wr_data[6], 2) && $past(wr_data[7], 2)) else $error("init");
    add_flags_a: assert property (add_w |=> alu_flags.carry == $past(sum_w[32]) &&
        alu_result == $past(sum_w[31:0])) else $error("add carry");
    add_ovf_a: assert property (add_w |=> alu_flags.overflow ==
        $past(alu_a[31] == alu_b[31] && sum_w[31] != alu_a[31])) else $error("add ovf");
    sub_carry_a: assert property (alu_valid && alu_op == op_sub |=>
        alu_flags.carry == $past(alu_a >= alu_b)) else $error("sub carry");
    zero_sign_a: assert property (alu_valid && alu_op != op_mult |=>
        alu_flags.zero == (alu_result == '0) && alu_flags.positive == !alu_result[31])
        else $error("zero sign");
endmodule : dsp_port_flags_monitor

bind dsp_port_flags dsp_port_flags_monitor mon_u (
    .clock, .resetn, .wr_en, .wr_data, .meas_pulse, .alu_valid, .alu_op, .alu_a, .alu_b,
    .alu_result, .alu_flags, .irq_release, .irq_line_n
);

// [dv/pin_world.sv]
`timescale 1ns/1ps
`include "port_cfg.svh"
module pin_world
    import port_pkg::*;
(
    input pin_drive_t                pin_drive,
    input wire logic [`NUM_PINS-1:0] sw_level,
    output logic     [`NUM_PINS-1:0] pin_in
);
    assign pin_in = (pin_drive.value & ~pin_drive.oe_n) | (sw_level & pin_drive.oe_n);
endmodule : pin_world

// [dv/dsp_port_flags_tb_top.sv]
`timescale 1ns/1ps
`include "port_cfg.svh"
module dsp_port_flags_tb_top
    import port_pkg::*;
;
    logic        clock = 0, resetn = 0, wr_en = 0, alu_valid = 0, spi_mode = 0, spi_miso = 0;
    logic        irq_rel = 0, dsp_stop = 0, irq_q = 1, ssn, irqn, dstart;
    logic [15:0] wr_data = '0, d;
    logic [31:0] alu_a = '0, alu_b = '0, res;
    logic [9:0]  ctl = '0, c;
    logic [3:0]  dir = '0, mask = '0, io_rd;
    logic [1:0]  sel = 2'h0;
    logic [5:0]  sw = 6'h3f, pin_in, ev, ge = 6'h06;
    logic [2:0]  g1 = 3'h2, g2 = 3'h6;
    logic [7:0]  cond;
    logic [4:0]  pm [3] = '{5'h10, 5'h08, 5'h04};
    int          pb [3] = '{8, 9, 13};
    int          ns;
    alu_op_t     alu_op = op_add;
    meas_pulse_t mp;
    alu_flags_t  flg;
    pin_drive_t  pd;
    integer      seed = 32'hd646d58f, err_count = 0, n_checks = 0;

    dsp_port_flags dut_u (
        .clock, .resetn, .wr_en, .wr_data, .io_rd_bits(io_rd), .meas_pulse(mp), .alu_valid,
        .alu_op, .alu_a, .alu_b, .alu_result(res), .alu_flags(flg), .spi_mode, .spi_miso,
        .pulse_code_a(ctl[9]), .pulse_code_b(ctl[8]), .pulse_a_en(ctl[7]),
        .pulse_b_en(ctl[6]), .pulse_a_to_c(ctl[5]), .pulse_b_to_d(ctl[4]),
        .pin_dir_in(dir), .latch_mask(mask), .start_pin_sel(sel), .dsp_stop,
        .guard_mux_select(ctl[3]), .pin_e_guard_sel(ctl[2]), .irq_on_pin_e_en(ctl[1]),
        .irq_on_pin_f_en(ctl[0]), .irq_release(irq_rel), .pin_in, .pin_drive(pd),
        .spi_ssn(ssn), .irq_line_n(irqn), .dsp_start(dstart), .cond_inputs(cond)
    );
    pin_world ext_u (.pin_drive(pd), .sw_level(sw), .pin_in);

    always #10 clock = ~clock;

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc

    task automatic wr(input logic [15:0] v);
        @(posedge clock);
        wr_en   <= 1'b1;
        wr_data <= v;
        @(posedge clock);
        wr_en   <= 1'b0;
        #1;
    endtask : wr

    task automatic starts(output int n);
        n = 0;
        repeat (6) begin
            cyc(1);
            n += dstart;
        end
    endtask : starts

    task automatic alu_run(input alu_op_t op, input logic [31:0] a, input logic [31:0] b);
        logic [63:0] p;
        logic [31:0] r;
        logic        ov, cy;
        @(posedge clock);
        alu_valid <= 1'b1;
        alu_op    <= op;
        alu_a     <= a;
        alu_b     <= b;
        @(posedge clock);
        alu_valid <= 1'b0;
        #1;
        {ov, cy, r} = {2'b00, a};
        case (op)
            op_add: {cy, r} = {1'b0, a} + {1'b0, b};
            op_sub: {cy, r} = {a >= b, a - b};
            op_mult: begin
                p  = $signed(a) * $signed(b);
                r  = p[31:0];
                cy = 64'(a) * 64'(b) >= 64'h1_0000_0000;
                ov = p[63:31] != {33{p[63]}};
            end
            op_div: begin
                ov = b == '0 || (a == `DATA_MIN && b == `DATA_ONES);
                r  = ov ? '0 : $unsigned($signed(a) / $signed(b));
            end
            op_shl: r = a << b[4:0];
            op_shr: r = a >> b[4:0];
            default: ;
        endcase
        if (op inside {op_add, op_sub}) begin
            ov = a[31] == (b[31] ^ (op == op_sub)) && r[31] != a[31];
        end
        chk(flg[3:2], {ov, cy}, "ovf carry");
        chk(res, r, "alu result");
        chk(flg[1:0], {r == '0, !r[31]}, "zero sign");
    endtask : alu_run

    initial begin
        #200000;
        err_count++;
        close_out();
    end

    initial begin
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        foreach (pb[i]) begin
            wr(16'h0001 << pb[i]);
            chk(mp, pm[i], "pulse");
            cyc(1);
            chk(mp, 0, "pulse clear");
        end
        wr(16'h0800);
        irq_q = 1'b0;
        chk(irqn, 0, "irq set");
        for (int k = 0; k < 3; k++) begin
            wr({8'h00, g1[k], 7'h40});
            wr({8'h00, g2[k], 7'h00});
            cyc(1);
            chk(mp[1:0], ge[k*2+:2], "guard");
        end
        alu_run(op_add, `DATA_ONES, 32'h0000_0001);
        alu_run(op_add, 32'h7fff_ffff, 32'h0000_0001);
        alu_run(op_sub, 32'h0000_0001, 32'h0000_0002);
        alu_run(op_sub, `DATA_MIN, 32'h0000_0001);
        alu_run(op_div, `DATA_MIN, `DATA_ONES);
        alu_run(op_mult, 32'h0001_0000, 32'h0001_0000);
        for (int i = 0; i < 200; i++) begin
            alu_run(alu_op_t'(3'($unsigned($random(seed)) % 7)), $random(seed), $random(seed));
        end
        for (int i = 0; i < 40; i++) begin
            c = $random(seed);
            d = $random(seed) & 16'h083f;
            d[3:2] = d[3:2] & ~{c[6] & c[4], c[7] & c[5]};
            @(posedge clock);
            ctl <= c;
            wr(d);
            irq_q = irq_q & ~d[11];
            ev = {c[0] ? irq_q : d[5], c[1] ? irq_q : (c[2] ? c[3] : d[4]),
                  d[3:2] | {c[8] & c[6] & c[4], c[9] & c[7] & c[5]},
                  d[1:0] | {c[8] & c[6] & ~c[4], c[9] & c[7] & ~c[5]}};
            cyc(2);
            chk(pd, {ev, 6'h00}, "pins");
            chk(io_rd, d[3:0], "io read");
        end
        @(posedge clock);
        irq_rel <= 1'b1;
        @(posedge clock);
        irq_rel <= 1'b0;
        #1;
        chk(irqn, 1, "irq release");
        @(posedge clock);
        dir  <= 4'hf;
        mask <= 4'h5;
        ctl  <= '0;
        cyc(4);
        @(posedge clock);
        sw <= 6'h3c;
        starts(ns);
        chk(ns, 1, "start pulse");
        chk(cond, 8'h01, "latch a");
        chk(io_rd, 4'hc, "pin read");
        @(posedge clock);
        dsp_stop <= 1'b1;
        sw       <= 6'h38;
        @(posedge clock);
        dsp_stop <= 1'b0;
        starts(ns);
        chk(ns, 0, "no start");
        chk(cond, 8'h04, "latch c");
        @(posedge clock);
        sel <= 2'h2;
        sw  <= 6'h3c;
        cyc(4);
        @(posedge clock);
        sw <= 6'h38;
        starts(ns);
        chk(ns, 1, "start sel c");
        @(posedge clock);
        spi_mode <= 1'b1;
        spi_miso <= 1'b1;
        cyc(4);
        chk(ssn, 0, "ssn");
        chk({pd.value[1], pd.oe_n[1:0]}, 3'h5, "miso");
        @(posedge clock);
        resetn <= 1'b0;
        cyc(1);
        chk({pd, irqn, ssn, dstart, cond, io_rd}, {12'h03f, 3'h6, 12'h000}, "reset");
        chk(res, 0, "reset result");
        chk({flg, mp}, 0, "reset flags");
        @(posedge clock);
        resetn <= 1'b1;
        wr(16'h0100);
        chk(mp, 5'h10, "kick after reset");
        close_out();
    end
endmodule : dsp_port_flags_tb_top
